// >>> src/eeprom_array.sv
// flip-flop byte array, single port, combinational read
`include "eeprom_map.svh"
module eeprom_array (
  // clock
  input  wire logic                  i_clk,
  // access port
  input  wire logic                  i_we,
  input  wire logic [`EE_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]            i_wdata,
  output logic      [7:0]            o_rdata
);
  logic [7:0] mem [`EE_DEPTH];  // storage, no reset: contents are data

  // byte write at the indexed location
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // read is the indexed location
  assign o_rdata = mem[i_addr];
endmodule // eeprom_array

// >>> src/eeprom_map.svh
// constants for the two-wire serial eeprom slave
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define EE_ADDR_W        13
`define EE_DEPTH         8192
`define EE_PAGE_HI       4
`define EE_DEV_CODE      4'ha
`define EE_CMD_PROT_ON   8'hf0
`define EE_CMD_PROT_OFF  8'h80
`define EE_AHI_CFG       7
`define EE_CFG_SEL_HI    6
`define EE_CFG_SEL_LO    4
`define EE_CFG_SWP       0
`define EE_CFG_MASK      8'h71
`define EE_CFG_RESET     8'h00
`define EE_BIT_LAST      4'h7
`define EE_BIT_FULL      4'h8
`define EE_FIFO_W        21
`define EE_FIFO_D        8
`define EE_PROG_TIME_NS  3000000
`define EE_CLK_PERIOD_NS 5
`endif

// >>> src/eeprom_pkg.sv
// types and decode helpers for the two-wire serial eeprom slave
`include "eeprom_map.svh"
package eeprom_pkg;
  // bus engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,  // standby, waits for start
    ST_RX   = 6'h02,  // shifting in a byte
    ST_ACK  = 6'h04,  // ninth clock, device side
    ST_TX   = 6'h08,  // shifting out a byte
    ST_RACK = 6'h10,  // ninth clock, master answers
    ST_BUSY = 6'h20   // internal programming cycle
  } bus_state_t;

  // byte position within a command, one-hot
  typedef enum logic [3:0] {
    PH_DEV  = 4'h1,
    PH_AHI  = 4'h2,
    PH_ALO  = 4'h4,
    PH_DATA = 4'h8
  } phase_t;

  // what follows the ninth clock, one-hot
  typedef enum logic [2:0] {
    AF_IDLE = 3'h1,
    AF_RX   = 3'h2,
    AF_TX   = 3'h4
  } after_t;

  // device address byte matches code and select bits
  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
    return (b[7:4] == `EE_DEV_CODE) && (b[3:1] == sel);
  endfunction
endpackage : eeprom_pkg

// >>> src/i2c_serial_eeprom_slave.sv
// two-wire serial eeprom slave: bus engine, addressing, protection, programming timer
//
// Overview of operation
// - sample data on clock rise, drive after fall
// - data moves high-clock only as start/stop
// - start recognised anytime except while programming runs, restarts command decode
// - stop ends read, returns to standby
// - eight-bit words, acknowledge on ninth clock
// - standby at reset and after stop/programming
// - 256 pages of 32 bytes, 13-bit address
// - device address: fixed code plus select bits
// - address lsb picks read or write
// - writes carry two word-address bytes
// - stop after data starts timed programming
// - bus ignored while programming runs
// - page write up to 32 bytes
// - page writes wrap within five low bits
// - command f0 after start sets protection
// - command 80 after start clears protection
// - address counter keeps last address plus one
// - reads wrap from last to first byte
// - current read sends byte at counter
// - master ack continues sequential read
// - config register at word address msb set
`include "eeprom_map.svh"
module i2c_serial_eeprom_slave #(
  parameter int unsigned WR_CYCLES = `EE_PROG_TIME_NS / `EE_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // two-wire bus, open drain data
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_out,
  output logic      o_sda_oe,
  // status
  output logic      o_standby,
  output logic      o_write_busy,
  output logic      o_protected
);
  import eeprom_pkg::*;

  logic                  scl_q;       // previous clock line
  logic                  sda_q;       // previous data line
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_det;
  logic                  stop_det;
  bus_state_t            state_q;     // bus engine state
  phase_t                phase_q;     // byte position
  after_t                after_q;     // action after ninth clock
  after_t                after_d;
  logic                  ack_q;       // acknowledge decided for last byte
  logic                  ack_d;
  logic [3:0]            bit_cnt_q;   // bits moved in current byte
  logic [7:0]            shift_q;     // receive shifter
  logic [7:0]            tx_q;        // transmit shifter
  logic [7:0]            rx_byte;     // byte completing this rise
  logic                  byte_rise;   // eighth rising edge of a byte
  logic [`EE_ADDR_W-1:0] addr_q;      // word address counter
  logic                  cfg_sel_q;   // config register addressed
  logic [7:0]            cfg_q;       // config register
  logic                  prot_q;      // software write protection
  logic                  wrote_q;     // data queued since last programming cycle
  logic [19:0]           timer_q;     // programming countdown
  logic                  sda_oe_q;    // pulling data line low
  logic                  tx_load;     // fetch and drive first bit
  logic [7:0]            tx_byte;
  logic                  fetch_win;   // array port held for reads
  logic                  fifo_push;
  logic                  fifo_rdy;
  logic                  fifo_vld;
  logic [`EE_FIFO_W-1:0] fifo_out;
  logic [`EE_ADDR_W-1:0] arr_addr;
  logic [7:0]            arr_rdata;

  // line edge history
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign scl_rise  = i_scl && !scl_q;
  assign scl_fall  = !i_scl && scl_q;
  assign start_det = scl_q && i_scl && sda_q && !i_sda;
  assign stop_det  = scl_q && i_scl && !sda_q && i_sda;
  assign rx_byte   = {shift_q[6:0], i_sda};
  assign byte_rise = (state_q == ST_RX) && scl_rise && (bit_cnt_q == `EE_BIT_LAST);
  assign tx_load   = (state_q == ST_ACK) && scl_fall && (after_q == AF_TX);
  assign tx_byte   = cfg_sel_q ? cfg_q : arr_rdata;
  assign fetch_win = (state_q == ST_ACK) || (state_q == ST_RACK);

  // acknowledge decision for the byte completing now
  always_comb begin
    ack_d   = 1'b0;
    after_d = AF_IDLE;
    case (phase_q)
      PH_DEV: begin
        if (rx_byte == `EE_CMD_PROT_ON || rx_byte == `EE_CMD_PROT_OFF) begin
          ack_d = 1'b1;
        end else if (dev_match(rx_byte, cfg_q[`EE_CFG_SEL_HI:`EE_CFG_SEL_LO])) begin
          ack_d   = 1'b1;
          after_d = rx_byte[0] ? AF_TX : AF_RX;
        end
      end
      PH_AHI, PH_ALO: begin
        ack_d   = 1'b1;
        after_d = AF_RX;
      end
      PH_DATA: begin
        if (cfg_sel_q || (!prot_q && fifo_rdy)) begin
          ack_d   = 1'b1;
          after_d = AF_RX;
        end
      end
      default: begin
        ack_d = 1'b0;
      end
    endcase
  end

  assign fifo_push = byte_rise && (phase_q == PH_DATA) && !cfg_sel_q && !prot_q && fifo_rdy;

  // bus engine: bit timing and ninth-clock handling
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      sda_oe_q  <= 1'b0;
      ack_q     <= 1'b0;
      after_q   <= AF_IDLE;
    end else if (state_q == ST_BUSY) begin
      sda_oe_q <= 1'b0;
      if (timer_q == 20'h00000 && !fifo_vld) begin
        state_q <= ST_IDLE;
      end
    end else if (start_det) begin
      state_q   <= ST_RX;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end else if (stop_det) begin
      state_q  <= wrote_q ? ST_BUSY : ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise && bit_cnt_q != `EE_BIT_FULL) begin
            shift_q   <= rx_byte;
            bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            if (bit_cnt_q == `EE_BIT_LAST) begin
              ack_q   <= ack_d;
              after_q <= after_d;
            end
          end else if (scl_fall && bit_cnt_q == `EE_BIT_FULL) begin
            sda_oe_q <= ack_q;
            state_q  <= ack_q ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            case (after_q)
              AF_RX: begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_RX;
              end
              AF_TX: begin
                sda_oe_q <= !tx_byte[7];
                tx_q     <= {tx_byte[6:0], 1'b0};
                state_q  <= ST_TX;
              end
              default: begin
                sda_oe_q <= 1'b0;
                state_q  <= ST_IDLE;
              end
            endcase
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == `EE_BIT_LAST) begin
              sda_oe_q <= 1'b0;  // release for master answer
              state_q  <= ST_RACK;
            end else begin
              sda_oe_q  <= !tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
              bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            after_q <= AF_TX;
            state_q <= i_sda ? ST_IDLE : ST_ACK;
          end
        end
        ST_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q  <= ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // command decode: byte position, address, config, protection
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q   <= PH_DEV;
      addr_q    <= '0;
      cfg_sel_q <= 1'b0;
      cfg_q     <= `EE_CFG_RESET;
      prot_q    <= 1'b0;
      wrote_q   <= 1'b0;
    end else if (state_q == ST_BUSY) begin
      wrote_q <= 1'b0;
    end else if (start_det) begin
      phase_q <= PH_DEV;
    end else if (stop_det) begin
      phase_q <= PH_DEV;
    end else if (byte_rise) begin
      case (phase_q)
        PH_DEV: begin
          if (rx_byte == `EE_CMD_PROT_ON) begin
            prot_q <= 1'b1;
          end else if (rx_byte == `EE_CMD_PROT_OFF) begin
            prot_q <= 1'b0;
          end else if (ack_d && !rx_byte[0]) begin
            phase_q <= PH_AHI;
          end
        end
        PH_AHI: begin
          cfg_sel_q    <= rx_byte[`EE_AHI_CFG];
          addr_q[12:8] <= rx_byte[4:0];
          phase_q      <= PH_ALO;
        end
        PH_ALO: begin
          addr_q[7:0] <= rx_byte;
          phase_q     <= PH_DATA;
        end
        PH_DATA: begin
          if (cfg_sel_q) begin
            cfg_q <= rx_byte & `EE_CFG_MASK;
          end else if (fifo_push) begin
            addr_q[`EE_PAGE_HI:0] <= 5'(addr_q[`EE_PAGE_HI:0] + 5'h01);
            wrote_q               <= 1'b1;
          end
        end
        default: begin
          phase_q <= PH_DEV;
        end
      endcase
    end else if (tx_load && !cfg_sel_q) begin
      addr_q <= 13'(addr_q + 13'h0001);
    end
  end

  // programming cycle countdown
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_q <= 20'h00000;
    end else if (state_q != ST_BUSY && stop_det && wrote_q) begin
      timer_q <= 20'(WR_CYCLES - 1);
    end else if (state_q == ST_BUSY && timer_q != 20'h00000) begin
      timer_q <= 20'(timer_q - 20'h00001);
    end
  end

  // registered outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sda_out    <= 1'b0;
      o_sda_oe     <= 1'b0;
      o_standby    <= 1'b1;
      o_write_busy <= 1'b0;
      o_protected  <= 1'b0;
    end else begin
      o_sda_out    <= 1'b0;  // open drain: only ever pulls low
      o_sda_oe     <= sda_oe_q;
      o_standby    <= (state_q == ST_IDLE);
      o_write_busy <= (state_q == ST_BUSY);
      o_protected  <= prot_q;
    end
  end

  // write queue between receiver and array; reads hold the port
  sync_fifo #(
    .WIDTH (`EE_FIFO_W),
    .DEPTH (`EE_FIFO_D)
  ) sync_fifo_inst (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (fifo_push),
    .o_ready (fifo_rdy),
    .i_data  ({addr_q, rx_byte}),
    .o_valid (fifo_vld),
    .i_ready (!fetch_win),
    .o_data  (fifo_out)
  );

  assign arr_addr = fetch_win ? addr_q : fifo_out[`EE_FIFO_W-1:8];

  // byte storage
  eeprom_array eeprom_array_inst (
    .i_clk   (i_clk),
    .i_we    (fifo_vld && !fetch_win),
    .i_addr  (arr_addr),
    .i_wdata (fifo_out[7:0]),
    .o_rdata (arr_rdata)
  );

  // checks
  a_ack_ninth: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == ST_RX && scl_fall && bit_cnt_q == `EE_BIT_FULL && ack_q && !start_det && !stop_det)
    |=> sda_oe_q && state_q == ST_ACK)
    else $error("ack not driven on ninth clock");
  a_busy_silent: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_q == ST_BUSY) |=> !sda_oe_q)
    else $error("data line driven while programming");
  a_start_restart: assert property (@(posedge i_clk) disable iff (i_rst)
    (start_det && state_q != ST_BUSY) |=> state_q == ST_RX && phase_q == PH_DEV && bit_cnt_q == 4'h0)
    else $error("start not recognised");
  a_stop_standby: assert property (@(posedge i_clk) disable iff (i_rst)
    (stop_det && state_q != ST_BUSY && !wrote_q) |=> state_q == ST_IDLE ##1 o_standby)
    else $error("stop did not return to standby");
  a_stop_program: assert property (@(posedge i_clk) disable iff (i_rst)
    (stop_det && state_q != ST_BUSY && wrote_q) |=> state_q == ST_BUSY && timer_q == 20'(WR_CYCLES - 1))
    else $error("programming cycle not started");
  a_page_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    fifo_push |=> addr_q[12:5] == $past(addr_q[12:5])
      && addr_q[4:0] == 5'($past(addr_q[4:0]) + 5'h01))
    else $error("page address did not wrap in page");
  a_read_incr: assert property (@(posedge i_clk) disable iff (i_rst)
    (tx_load && !cfg_sel_q && !start_det && !stop_det) |=> addr_q == 13'($past(addr_q) + 13'h0001))
    else $error("read address not incremented");
  a_prot_cmds: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_rise && phase_q == PH_DEV && !start_det && !stop_det)
    |=> (prot_q == ($past(rx_byte) == `EE_CMD_PROT_ON))
      || ($past(rx_byte) != `EE_CMD_PROT_OFF && prot_q == $past(prot_q)))
    else $error("protection command mishandled");
  a_prot_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
    (prot_q && byte_rise && phase_q == PH_DATA && !cfg_sel_q)
    |-> !fifo_push ##1 !ack_q)
    else $error("write accepted while protected");
  a_nomatch_nack: assert property (@(posedge i_clk) disable iff (i_rst)
    (byte_rise && phase_q == PH_DEV && !start_det && !stop_det
      && !dev_match(rx_byte, cfg_q[`EE_CFG_SEL_HI:`EE_CFG_SEL_LO])
      && rx_byte != `EE_CMD_PROT_ON && rx_byte != `EE_CMD_PROT_OFF) |=> !ack_q)
    else $error("foreign address acknowledged");
  a_drive_low_clk: assert property (@(posedge i_clk) disable iff (i_rst)
    ($changed(sda_oe_q) && !$past(start_det) && !$past(stop_det)) |-> !scl_q)
    else $error("data line changed while clock high");

  c_byte_write: cover property (@(posedge i_clk) disable iff (i_rst)
    fifo_push ##[1:1000] state_q == ST_BUSY);
  c_seq_read: cover property (@(posedge i_clk) disable iff (i_rst)
    (state_q == ST_RACK && scl_rise && !i_sda) ##[1:1000] tx_load);
  c_prot_on: cover property (@(posedge i_clk) disable iff (i_rst)
    $rose(prot_q));
  c_cfg_write: cover property (@(posedge i_clk) disable iff (i_rst)
    byte_rise && phase_q == PH_DATA && cfg_sel_q);
endmodule // i2c_serial_eeprom_slave

// >>> src/sync_fifo.sv
// synchronous fifo with valid/ready on both sides
module sync_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];  // storage
  logic [AW-1:0]    wr_q;           // write index
  logic [AW-1:0]    rd_q;           // read index
  logic [AW:0]      cnt_q;          // fill level
  logic             push;
  logic             pop;

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = buf_q[rd_q];

  // storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      buf_q[wr_q] <= i_data;
    end
  end

  // indices and level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + (AW+1)'(push) - (AW+1)'(pop));
    end
  end
endmodule // sync_fifo

// >>> testbench/bus_master_model.sv
// two-wire bus master model: clock line and open-drain data
module bus_master_model #(
  parameter int HALF = 8  // i_clk cycles per bus clock phase
) (
  // system clock
  input  wire logic i_clk,
  // bus levels
  input  wire logic i_sda,  // resolved data line
  output logic      o_scl,  // clock line level
  output logic      o_sda   // 1 releases to pull-up, 0 pulls low
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // one clock phase
  task automatic phase();
    repeat (HALF) @(posedge i_clk);
  endtask

  // one clock pulse, data moves only while clock low, sampled mid-high
  task automatic pulse(input logic b, output logic s);
    o_sda <= b;
    phase();
    o_scl <= 1'b1;
    repeat (HALF / 2) @(posedge i_clk);
    @(negedge i_clk);
    s = i_sda;
    repeat (HALF / 2) @(posedge i_clk);
    o_scl <= 1'b0;
    phase();
  endtask

  // start: data falls with clock high
  task automatic start();
    o_sda <= 1'b1;
    phase();
    o_scl <= 1'b1;
    phase();
    o_sda <= 1'b0;
    phase();
    o_scl <= 1'b0;
    phase();
  endtask

  // stop: data rises with clock high, bus left idle
  task automatic stop();
    o_sda <= 1'b0;
    phase();
    o_scl <= 1'b1;
    phase();
    o_sda <= 1'b1;
    phase();
  endtask

  // eight bits msb first, then sample the device acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, s);
    ack = ~s;
  endtask

  // take eight bits, then acknowledge or not
  task automatic recv(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      b[i] = s;
    end
    pulse(~mack, s);
  endtask

  // bus recovery: nine clocks with data released
  task automatic recover();
    logic s;
    for (int i = 0; i < 9; i++) pulse(1'b1, s);
  endtask
endmodule // bus_master_model

// >>> testbench/i2c_serial_eeprom_slave_tb.sv
// self-checking bench for the two-wire serial eeprom slave
module i2c_serial_eeprom_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_clk;         // system clock
  logic       i_rst;         // async reset
  logic       scl;           // bus clock from master
  logic       m_sda;         // master data drive
  logic       sda_bus;       // resolved data wire
  logic       o_sda_out;     // device data value
  logic       o_sda_oe;      // device pulls low
  logic       o_standby;     // engine idle
  logic       o_write_busy;  // programming runs
  logic       o_protected;   // write protection on
  int         miscompares;   // mismatch count
  int         n_tests;       // comparison count
  int         cyc;           // timeout counter

  // open drain with pull-up
  assign sda_bus = m_sda & (o_sda_oe ? o_sda_out : 1'b1);

  i2c_serial_eeprom_slave #(.WR_CYCLES(2000)) i2c_serial_eeprom_slave_inst (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_scl        (scl),
    .i_sda        (sda_bus),
    .o_sda_out    (o_sda_out),
    .o_sda_oe     (o_sda_oe),
    .o_standby    (o_standby),
    .o_write_busy (o_write_busy),
    .o_protected  (o_protected)
  );

  bus_master_model #(.HALF(8)) bus_master_model_inst (
    .i_clk (i_clk),
    .i_sda (sda_bus),
    .o_scl (scl),
    .o_sda (m_sda)
  );

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // compare and report
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // start, device byte, ack expected or not
  task automatic dev(input logic [7:0] b, input logic exp);
    logic ack;
    bus_master_model_inst.start();
    bus_master_model_inst.send(b, ack);
    check("device ack", {7'h00, exp}, {7'h00, ack});
  endtask

  // write header: device byte and two word-address bytes
  task automatic hdr(input logic [12:0] a);
    logic ack;
    dev(8'ha0, 1'b1);
    bus_master_model_inst.send({3'h0, a[12:8]}, ack);
    check("addr hi ack", 8'h01, {7'h00, ack});
    bus_master_model_inst.send(a[7:0], ack);
    check("addr lo ack", 8'h01, {7'h00, ack});
  endtask

  // bounded wait for standby
  task automatic wait_idle();
    for (int i = 0; i < 3000 && o_standby !== 1'b1; i++) @(posedge i_clk);
    check("standby", 8'h01, {7'h00, o_standby});
  endtask

  // n data bytes from d0 upward, then stop
  task automatic wr_seq(input logic [12:0] a, input logic [7:0] d0, input int n);
    logic ack;
    hdr(a);
    for (int i = 0; i < n; i++) begin
      bus_master_model_inst.send(d0 + 8'(i), ack);
      check("data ack", 8'h01, {7'h00, ack});
    end
    bus_master_model_inst.stop();
    wait_idle();
  endtask

  // dummy write, repeated start, sequential read of expected bytes
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e[$]);
    logic [7:0] b;
    hdr(a);
    dev(8'ha1, 1'b1);
    foreach (e[i]) begin
      bus_master_model_inst.recv(i < e.size() - 1, b);
      check("read data", e[i], b);
    end
    bus_master_model_inst.stop();
    wait_idle();
  endtask

  task automatic t_reset();
    check("reset standby", 8'h01, {7'h00, o_standby});
    check("reset busy", 8'h00, {7'h00, o_write_busy});
    check("reset prot", 8'h00, {7'h00, o_protected});
    check("reset oe", 8'h00, {7'h00, o_sda_oe});
    check("reset sda out", 8'h00, {7'h00, o_sda_out});
  endtask

  // byte write, then a probe during the programming cycle
  task automatic t_busy();
    logic ack;
    hdr(13'h0100);
    bus_master_model_inst.send(8'h5a, ack);
    bus_master_model_inst.stop();
    check("busy", 8'h01, {7'h00, o_write_busy});
    dev(8'ha0, 1'b0);
    bus_master_model_inst.stop();
    wait_idle();
    rd_chk(13'h0100, '{8'h5a});
  endtask

  // page write past page end wraps to page start
  task automatic t_page();
    wr_seq(13'h005e, 8'hd0, 4);
    rd_chk(13'h005e, '{8'hd0, 8'hd1});
    rd_chk(13'h0040, '{8'hd2, 8'hd3});
  endtask

  // read wrap at top of memory, counter kept between operations
  task automatic t_wrap();
    logic [7:0] b;
    wr_seq(13'h1ffe, 8'h11, 2);
    wr_seq(13'h0000, 8'h33, 1);
    rd_chk(13'h1fff, '{8'h12, 8'h33});
    rd_chk(13'h1ffe, '{8'h11});
    dev(8'ha1, 1'b1);
    bus_master_model_inst.recv(1'b0, b);
    check("current read", 8'h12, b);
    bus_master_model_inst.stop();
    wait_idle();
  endtask

  // protection on refuses data, off again
  task automatic t_protect();
    logic ack;
    dev(8'hf0, 1'b1);
    bus_master_model_inst.stop();
    check("prot on", 8'h01, {7'h00, o_protected});
    hdr(13'h0100);
    bus_master_model_inst.send(8'ha5, ack);
    check("refused data", 8'h00, {7'h00, ack});
    bus_master_model_inst.stop();
    wait_idle();
    rd_chk(13'h0100, '{8'h5a});
    dev(8'h80, 1'b1);
    bus_master_model_inst.stop();
    check("prot off", 8'h00, {7'h00, o_protected});
  endtask

  // config register: masked write, select bits move the address, readback
  task automatic t_config();
    logic       ack;
    logic [7:0] b;
    dev(8'ha0, 1'b1);
    bus_master_model_inst.send(8'h80, ack);
    bus_master_model_inst.send(8'h00, ack);
    bus_master_model_inst.send(8'h9e, ack);
    check("cfg data ack", 8'h01, {7'h00, ack});
    bus_master_model_inst.stop();
    wait_idle();
    dev(8'ha0, 1'b0);
    dev(8'ha2, 1'b1);
    bus_master_model_inst.send(8'h80, ack);
    bus_master_model_inst.send(8'h00, ack);
    dev(8'ha3, 1'b1);
    bus_master_model_inst.recv(1'b0, b);
    check("cfg read", 8'h10, b);
    bus_master_model_inst.stop();
    wait_idle();
  endtask

  // wrong code or select bits get no acknowledge
  task automatic t_mismatch();
    dev(8'ha2, 1'b0);
    dev(8'h50, 1'b0);
    bus_master_model_inst.stop();
    check("mismatch oe", 8'h00, {7'h00, o_sda_oe});
  endtask

  // main sequence
  initial begin
    i_rst = 1'b1;
    miscompares = 0;
    n_tests = 0;
    cyc = 0;
    repeat (8) @(posedge i_clk);
    t_reset();
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    bus_master_model_inst.recover();
    t_mismatch();
    t_busy();
    t_page();
    t_wrap();
    t_protect();
    t_config();
    print_verdict();
  end
endmodule // i2c_serial_eeprom_slave_tb
